// File: tb/gpio_pins_assertions.sv
// checker: pin-level behaviour of the device end, watching the shared interface
// assumes one core clock and the device reset; placed beside the interface
`timescale 1ns/10ps
module gpio_pins_assertions (
	input wire logic            CORE_CLK_I,
	input wire logic            RESET_N_I,
	input wire logic            chip_select_low,
	input wire logic            read_strobe_low,
	input wire logic            write_strobe_low,
	input wire logic            standalone_mode_select,
	input wire logic            output_hold_low,
	input wire logic            output_enable_low,
	input wire logic            data_d_oe,
	input wire logic [3:0][7:0] port_out,
	input wire logic [3:0][7:0] port_oe,
	input wire logic [3:0][7:0] port_lvl
);
	logic       sel;
	logic       prev_w;
	logic [3:0] wr_age;
	assign sel = !chip_select_low && !read_strobe_low;
	// saturating age, so a stale write never excuses a late change
	always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			prev_w <= 1'b1;
			wr_age <= 4'hF;
		end else begin
			prev_w <= write_strobe_low;
			if (write_strobe_low && !prev_w && !chip_select_low)
				wr_age <= 4'h0;
			else if (wr_age != 4'hF)
				wr_age <= wr_age + 4'h1;
		end
	end
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RESET_N_I);
	sequence alone; !standalone_mode_select [*6]; endsequence
	sequence hosted; standalone_mode_select [*6]; endsequence
	sequence pass_a; (!standalone_mode_select && !write_strobe_low && output_hold_low
		&& $stable(port_lvl[0])) [*7]; endsequence
	sequence pass_b; (!standalone_mode_select && !read_strobe_low && output_hold_low
		&& $stable(port_lvl[1])) [*7]; endsequence
	bus_idle_a: assert property (alone |-> !data_d_oe)
		else $error("data bus driven in standalone");
	rd_drive_a: assert property (data_d_oe |-> $past(sel, 3) || $past(sel, 4))
		else $error("data bus driven without read");
	rd_answer_a: assert property ((sel && standalone_mode_select) [*5] |-> data_d_oe)
		else $error("read not answered");
	wr_load_a: assert property (hosted ##0 !$stable({port_out, port_oe})
		|-> wr_age inside {[1:8]}) else $error("port change without write");
	rst_quiet_a: assert property (disable iff (1'b0) !RESET_N_I
		|-> port_oe == '0 && !data_d_oe) else $error("pins driven in reset");
	cd_low_a: assert property (disable iff (1'b0) !RESET_N_I
		|-> port_out[3:2] == '0) else $error("C or D not low in reset");
	ab_input_a: assert property (alone |-> port_oe[1:0] == '0)
		else $error("A or B driven in standalone");
	oe_drive_a: assert property ((!standalone_mode_select && $stable(output_enable_low)) [*6]
		|-> port_oe[3:2] == {16{!output_enable_low}}) else $error("C/D enable wrong");
	hold_freeze_a: assert property ((!standalone_mode_select && !output_hold_low) [*6]
		|-> $stable(port_out[3:2])) else $error("C/D moved while held");
	a_bypass_a: assert property (pass_a |-> port_out[2] == port_lvl[0])
		else $error("C differs from A");
	b_bypass_a: assert property (pass_b |-> port_out[3] == port_lvl[1])
		else $error("D differs from B");
endmodule

// File: tb/tb_top.sv
// testbench: host end drives the device end across the pin interface
// assumes design files compiled first; host-slave checks, then standalone
`timescale 1ns/10ps
module tb_top;
	logic            core_clk;
	logic            rst_h_n;
	logic            rst_d_n;
	logic [2:0]      addr;
	logic [7:0]      wdata;
	logic            wr;
	logic            rd;
	logic [7:0]      rdata;
	logic            rd_d;
	logic            smp;
	logic [2:0]      smp_p;
	logic            acc_on;
	logic [7:0]      acc_c;
	logic [7:0]      acc_d;
	logic [7:0][7:0] obs;
	logic [7:0]      v;
	logic [7:0]      exp_q[$];
	int              failures;
	int              total_checks;
	int              p;

	gpio_pins_if pins ();
	// short filter base keeps the filter runs brief
	gpio_dev_end #(.FILT_BASE_CYC(2)) u_gpio_dev_end (.CORE_CLK_I(core_clk),
		.RESET_N_I(rst_d_n), .PINS(pins));
	gpio_host_end u_gpio_host_end (.CORE_CLK_I(core_clk), .RESET_N_I(rst_h_n),
		.ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .PINS(pins));
	gpio_pins_assertions u_gpio_pins_assertions (.CORE_CLK_I(core_clk), .RESET_N_I(rst_d_n),
		.chip_select_low(pins.chip_select_low), .read_strobe_low(pins.read_strobe_low),
		.write_strobe_low(pins.write_strobe_low), .data_d_oe(pins.data_d_oe),
		.standalone_mode_select(pins.standalone_mode_select), .port_lvl(pins.port_lvl),
		.output_hold_low(pins.output_hold_low), .output_enable_low(pins.output_enable_low),
		.port_out(pins.port_out), .port_oe(pins.port_oe));

	always #5 core_clk = ~core_clk;
	assign obs = {pins.port_out[3], pins.port_out[2], acc_d, acc_c, pins.port_lvl};

	task automatic take(input logic [7:0] g, input string what);
		total_checks++;
		if (exp_q.size() == 0 || g !== exp_q[0]) begin
			failures++;
			$display("CHECK FAILED t=%0t %s got %h", $time, what, g);
		end
		if (exp_q.size() != 0) void'(exp_q.pop_front());
	endtask
	task automatic cmp_rd(input logic [7:0] g); take(g, "read data"); endtask
	task automatic cmp_pin(input logic [7:0] g); take(g, "pin level"); endtask

	// watcher: a result is a read answer or a requested pin sample
	always @(posedge core_clk) begin
		rd_d <= rd && (addr == gpio_pkg::HOST_RDATA || addr == gpio_pkg::HOST_CFG0);
		if (rd_d) cmp_rd(rdata);
		if (smp) cmp_pin(obs[smp_p]);
		acc_c <= acc_on ? (acc_c | pins.port_lvl[2]) : 8'h00;
		acc_d <= acc_on ? (acc_d | pins.port_lvl[3]) : 8'h00;
	end

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [2:0] a);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
	endtask
	// one device bus cycle; busy polled under a bounded count
	task automatic xfer(input logic [3:0] c, input logic [7:0] d);
		int n;
		wr_reg(gpio_pkg::HOST_WDATA, d);
		wr_reg(gpio_pkg::HOST_CMD, {4'h0, c});
		for (n = 0; n < 40; n++) begin
			rd_reg(gpio_pkg::HOST_STATUS);
			@(negedge core_clk);
			if (rdata[0] === 1'b0) break;
		end
		if (n == 40) begin
			failures++;
			$display("CHECK FAILED t=%0t busy stuck", $time);
		end
	endtask
	task automatic rdev(input logic [2:0] a, input logic [7:0] e);
		xfer({1'b1, a}, 8'h00);
		exp_q.push_back(e);
		rd_reg(gpio_pkg::HOST_RDATA);
	endtask
	task automatic chk_pin(input logic [2:0] q, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge core_clk);
		smp_p <= q;
		smp <= 1'b1;
		@(posedge core_clk);
		smp <= 1'b0;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic final_report;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		final_report;
	end

	initial begin
		core_clk = 1'b0;
		{rst_h_n, rst_d_n, wr, rd, rd_d, smp, acc_on} = '0;
		{addr, smp_p, wdata} = '0;
		pins.port_ext = '0;
		failures = 0;
		total_checks = 0;
		void'($urandom(38024));
		cyc(16);
		rst_h_n <= 1'b1;
		rst_d_n <= 1'b1;
		for (p = 0; p < 4; p++) begin
			v = 8'($urandom);
			xfer({2'b01, p[1:0]}, 8'hFF);
			xfer({2'b00, p[1:0]}, v);
			chk_pin(p[2:0], v);
			rdev({1'b0, p[1:0]}, v);
		end
		rdev(3'h6, 8'hFF);
		v = 8'($urandom);
		pins.port_ext[0] <= v;
		xfer(4'h4, 8'h00);
		rdev(3'h0, v);
		// device reset alone, host keeps running
		pins.port_ext[2] <= 8'h5A;
		rst_d_n <= 1'b0;
		cyc(3);
		rst_d_n <= 1'b1;
		chk_pin(3'h2, 8'h5A);
		rdev(3'h6, 8'h00);
		v = 8'($urandom);
		pins.port_ext[0] <= v;
		pins.port_ext[1] <= ~v;
		wr_reg(gpio_pkg::HOST_CFG1, 8'h40);
		wr_reg(gpio_pkg::HOST_MODE, 8'h00);
		cyc(12);
		chk_pin(3'h2, v);
		chk_pin(3'h3, ~v);
		wr_reg(gpio_pkg::HOST_CFG1, 8'h00);
		cyc(6);
		pins.port_ext[0] <= ~v;
		cyc(10);
		chk_pin(3'h2, v);
		pins.port_ext[2] <= 8'hA5;
		wr_reg(gpio_pkg::HOST_CFG1, 8'hC0);
		cyc(8);
		chk_pin(3'h2, 8'hA5);
		// 4-cycle pulse passes a limit of 2 but not one of 8
		pins.port_ext[1:0] <= '0;
		wr_reg(gpio_pkg::HOST_CFG0, 8'h02);
		exp_q.push_back(8'h02);
		rd_reg(gpio_pkg::HOST_CFG0);
		wr_reg(gpio_pkg::HOST_CFG1, 8'h72);
		cyc(40);
		acc_on <= 1'b1;
		pins.port_ext[1:0] <= 16'hFFFF;
		cyc(4);
		pins.port_ext[1:0] <= '0;
		cyc(20);
		chk_pin(3'h4, 8'hF0);
		chk_pin(3'h5, 8'h00);
		acc_on <= 1'b0;
		pins.port_ext[1:0] <= 16'hFFFF;
		cyc(40);
		chk_pin(3'h2, 8'hFF);
		chk_pin(3'h3, 8'hFF);
		rst_d_n <= 1'b0;
		chk_pin(3'h6, 8'h00);
		chk_pin(3'h7, 8'h00);
		rst_d_n <= 1'b1;
		cyc(10);
		final_report;
	end
endmodule

// File: verilog/gpio_dev_end.sv
// device end of the gpio pin interface: host-slave register bus and standalone filter path
// assumes host pins are asynchronous; all are passed through two flip-flops first
`timescale 1ns/10ps
module gpio_dev_end #(
	parameter int FILT_BASE_CYC = gpio_pkg::FILT_BASE_CYC
) (
	input  wire logic CORE_CLK_I,
	input  wire logic RESET_N_I,
	gpio_pins_if.dev  PINS
);
	localparam int PW = gpio_pkg::PORT_W;
	localparam int CW = gpio_pkg::FILT_CNT_W;

	typedef struct packed {
		logic [gpio_pkg::NUM_PORTS-1:0][PW-1:0] port;
		logic                                   output_enable_low;
		logic                                   output_hold_low;
		logic                                   standalone_mode_select;
		logic                                   read_strobe_low;
		logic                                   write_strobe_low;
		logic                                   chip_select_low;
		logic [gpio_pkg::ADDR_W-1:0]            addr;
		logic [gpio_pkg::DATA_W-1:0]            data;
	} pins_s;

	typedef struct packed {
		pins_s                                  s1;
		pins_s                                  s2;
		logic                                   wr_prev;
		logic [gpio_pkg::NUM_PORTS-1:0][PW-1:0] out_val;
		logic [gpio_pkg::NUM_PORTS-1:0][PW-1:0] dir;
		logic [gpio_pkg::DATA_W-1:0]            rdata;
		logic                                   rdata_oe;
		logic [gpio_pkg::NUM_PORTS-1:0][PW-1:0] pout;
		logic [gpio_pkg::NUM_PORTS-1:0][PW-1:0] poe;
	} dev_s;

	// strobes idle high so the release of reset never looks like a write edge
	localparam pins_s PINS_IDLE = '{
		output_enable_low:      1'b1,
		output_hold_low:        1'b1,
		standalone_mode_select: 1'b1,
		read_strobe_low:        1'b1,
		write_strobe_low:       1'b1,
		chip_select_low:        1'b1,
		default:                '0
	};
	localparam dev_s DEV_RST = '{
		s1:      PINS_IDLE,
		s2:      PINS_IDLE,
		wr_prev: 1'b1,
		out_val: {gpio_pkg::NUM_PORTS{gpio_pkg::DEV_OUT_RST}},
		dir:     {gpio_pkg::NUM_PORTS{gpio_pkg::DEV_DIR_RST}},
		default: '0
	};

	dev_s              r;
	dev_s              n;
	pins_s             raw;
	logic [2*PW-1:0]   filt_in;
	logic [2*PW-1:0]   filt_out;
	logic              standalone;
	logic              wr_rise;
	logic [1:0]        sel;

	always_comb begin
		raw = '{
			port:                   PINS.port_lvl,
			output_enable_low:      PINS.output_enable_low,
			output_hold_low:        PINS.output_hold_low,
			standalone_mode_select: PINS.standalone_mode_select,
			read_strobe_low:        PINS.read_strobe_low,
			write_strobe_low:       PINS.write_strobe_low,
			chip_select_low:        PINS.chip_select_low,
			addr:                   PINS.addr,
			data:                   PINS.data_lvl
		};
	end

	assign filt_in = {r.s2.port[gpio_pkg::PORT_B], r.s2.port[gpio_pkg::PORT_A]};

	// durations count in core cycles; a slower clock stretches them in proportion
	for (genvar i = 0; i < 2 * PW; i++) begin : g_filt
		logic [3:0]    code;
		logic [CW-1:0] limit;
		logic          en;
		if (i >= PW) begin : g_b
			assign code = {r.s2.chip_select_low, r.s2.addr};
			assign en = r.s2.read_strobe_low;
		end else if (i >= PW / 2) begin : g_ah
			assign code = r.s2.data[7:4];
			assign en = r.s2.write_strobe_low;
		end else begin : g_al
			assign code = r.s2.data[3:0];
			assign en = r.s2.write_strobe_low;
		end
		assign limit = CW'(FILT_BASE_CYC) << code;
		integ_filter #(
			.CNT_W (CW)
		) u_filt (
			.clk_i   (CORE_CLK_I),
			.rst_n_i (RESET_N_I),
			.in_i    (filt_in[i]),
			.en_i    (en),
			.limit_i (limit),
			.out_o   (filt_out[i])
		);
	end

	assign standalone = !r.s2.standalone_mode_select;
	assign wr_rise = r.s2.write_strobe_low && !r.wr_prev;
	assign sel = r.s2.addr[1:0];

	always_comb begin
		n = r;
		n.s1 = raw;
		n.s2 = r.s1;
		n.wr_prev = r.s2.write_strobe_low;
		if (standalone) begin
			n.rdata_oe = 1'b0;
			n.pout[gpio_pkg::PORT_A] = '0;
			n.pout[gpio_pkg::PORT_B] = '0;
			n.poe[gpio_pkg::PORT_A] = '0;
			n.poe[gpio_pkg::PORT_B] = '0;
			if (r.s2.output_hold_low) begin
				n.pout[gpio_pkg::PORT_C] = filt_out[PW-1:0];
				n.pout[gpio_pkg::PORT_D] = filt_out[2*PW-1:PW];
			end
			n.poe[gpio_pkg::PORT_C] = {PW{!r.s2.output_enable_low}};
			n.poe[gpio_pkg::PORT_D] = {PW{!r.s2.output_enable_low}};
		end else begin
			// strobes without chip select are ignored
			if (wr_rise && !r.s2.chip_select_low) begin
				if (r.s2.addr[gpio_pkg::DEV_DIR_BIT])
					n.dir[sel] = r.s2.data;
				else
					n.out_val[sel] = r.s2.data;
			end
			if (r.s2.addr[gpio_pkg::DEV_DIR_BIT])
				n.rdata = r.dir[sel];
			else
				n.rdata = r.s2.port[sel];
			n.rdata_oe = !r.s2.chip_select_low && !r.s2.read_strobe_low;
			n.pout = r.out_val;
			n.poe = r.dir;
		end
	end

	// reset is a constant load only: ports back to input, C and D low, bus released
	always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I)
			r <= DEV_RST;
		else
			r <= n;
	end

	assign PINS.data_d = r.rdata;
	assign PINS.data_d_oe = r.rdata_oe;
	assign PINS.port_out = r.pout;
	assign PINS.port_oe = r.poe;
endmodule

// File: verilog/gpio_host_end.sv
// host end: turns register commands into asynchronous-style bus cycles on the pins
// assumes the device samples every pin through its own synchroniser
`timescale 1ns/10ps
module gpio_host_end (
	input  wire logic       CORE_CLK_I,
	input  wire logic       RESET_N_I,
	input  wire logic [2:0] ADDR_I,
	input  wire logic [7:0] WDATA_I,
	input  wire logic       WR_I,
	input  wire logic       RD_I,
	output logic [7:0]      RDATA_O,
	gpio_pins_if.host       PINS
);
	typedef struct packed {
		gpio_pkg::host_state_e state;
		logic [3:0]            cnt;
		logic [2:0]            cmd_addr;
		logic                  cmd_read;
		logic                  busy;
		logic [7:0]            wdata;
		logic [7:0]            rdata;
		logic [7:0]            cfg0;
		logic [7:0]            cfg1;
		logic [7:0]            mode;
		logic [7:0]            rd_out;
		logic [7:0]            data_h;
		logic                  data_h_oe;
		logic [2:0]            addr;
		logic                  cs_n;
		logic                  wr_n;
		logic                  rd_n;
		logic                  sel_n;
		logic                  hold_n;
		logic                  oe_n;
	} host_s;

	localparam host_s HOST_RST = '{
		state:   gpio_pkg::H_IDLE,
		cfg0:    gpio_pkg::CFG0_RST,
		cfg1:    gpio_pkg::CFG1_RST,
		mode:    gpio_pkg::MODE_RST,
		cs_n:    1'b1,
		wr_n:    1'b1,
		rd_n:    1'b1,
		sel_n:   1'b1,
		hold_n:  1'b1,
		oe_n:    1'b1,
		default: '0
	};

	host_s r;
	host_s n;

	always_comb begin
		n = r;
		n.rd_out = '0;
		if (RD_I) begin
			unique case (ADDR_I)
				gpio_pkg::HOST_CMD:    n.rd_out = {4'h0, r.cmd_read, r.cmd_addr};
				gpio_pkg::HOST_WDATA:  n.rd_out = r.wdata;
				gpio_pkg::HOST_STATUS: n.rd_out = {7'h00, r.busy};
				gpio_pkg::HOST_RDATA:  n.rd_out = r.rdata;
				gpio_pkg::HOST_CFG0:   n.rd_out = r.cfg0;
				gpio_pkg::HOST_CFG1:   n.rd_out = r.cfg1;
				gpio_pkg::HOST_MODE:   n.rd_out = r.mode;
				default:               n.rd_out = '0;
			endcase
		end
		if (WR_I) begin
			unique case (ADDR_I)
				gpio_pkg::HOST_CMD: begin
					// a new command while busy is dropped
					if (!r.busy) begin
						n.cmd_addr = WDATA_I[2:0];
						n.cmd_read = WDATA_I[gpio_pkg::CMD_READ_BIT];
						n.busy = 1'b1;
						n.state = gpio_pkg::H_SETUP;
						n.cnt = 4'(gpio_pkg::SETUP_CYC - 1);
					end
				end
				gpio_pkg::HOST_WDATA: n.wdata = WDATA_I;
				gpio_pkg::HOST_CFG0:  n.cfg0 = WDATA_I;
				gpio_pkg::HOST_CFG1:  n.cfg1 = WDATA_I;
				gpio_pkg::HOST_MODE:  n.mode = WDATA_I;
				default:              n.cfg0 = r.cfg0;
			endcase
		end
		unique case (r.state)
			gpio_pkg::H_IDLE: n.cnt = r.cnt;
			gpio_pkg::H_SETUP: begin
				n.cnt = r.cnt - 1'b1;
				if (r.cnt == '0) begin
					n.state = gpio_pkg::H_STROBE;
					n.cnt = 4'(gpio_pkg::STROBE_CYC - 1);
				end
			end
			gpio_pkg::H_STROBE: begin
				n.cnt = r.cnt - 1'b1;
				if (r.cnt == '0) begin
					if (r.cmd_read)
						n.rdata = PINS.data_lvl;
					n.state = gpio_pkg::H_HOLD;
					n.cnt = 4'(gpio_pkg::HOLD_CYC - 1);
				end
			end
			gpio_pkg::H_HOLD: begin
				n.cnt = r.cnt - 1'b1;
				if (r.cnt == '0) begin
					n.state = gpio_pkg::H_IDLE;
					n.busy = 1'b0;
				end
			end
		endcase
		if (!n.mode[0]) begin
			// standalone: the bus pins carry static configuration levels
			n.sel_n = 1'b0;
			n.data_h = n.cfg0;
			n.data_h_oe = 1'b1;
			n.addr = n.cfg1[2:0];
			n.cs_n = n.cfg1[gpio_pkg::CFG1_CSN_BIT];
			n.wr_n = n.cfg1[gpio_pkg::CFG1_PORT_A_FILTER_ENABLE_PIN_BIT];
			n.rd_n = n.cfg1[gpio_pkg::CFG1_PORT_B_FILTER_ENABLE_PIN_BIT];
			n.hold_n = n.cfg1[gpio_pkg::CFG1_HOLDN_BIT];
			n.oe_n = n.cfg1[gpio_pkg::CFG1_OEN_BIT];
		end else begin
			n.sel_n = 1'b1;
			n.hold_n = 1'b1;
			n.oe_n = 1'b1;
			n.addr = n.cmd_addr;
			n.cs_n = (n.state == gpio_pkg::H_IDLE);
			n.wr_n = !(n.state == gpio_pkg::H_STROBE && !n.cmd_read);
			n.rd_n = !(n.state == gpio_pkg::H_STROBE && n.cmd_read);
			n.data_h = n.wdata;
			n.data_h_oe = !n.cmd_read && (n.state != gpio_pkg::H_IDLE);
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I)
			r <= HOST_RST;
		else
			r <= n;
	end

	assign RDATA_O = r.rd_out;
	assign PINS.data_h = r.data_h;
	assign PINS.data_h_oe = r.data_h_oe;
	assign PINS.addr = r.addr;
	assign PINS.chip_select_low = r.cs_n;
	assign PINS.write_strobe_low = r.wr_n;
	assign PINS.read_strobe_low = r.rd_n;
	assign PINS.standalone_mode_select = r.sel_n;
	assign PINS.output_hold_low = r.hold_n;
	assign PINS.output_enable_low = r.oe_n;
endmodule

// File: verilog/gpio_pins_if.sv
// pins between the gpio device end and the host end
// the testbench drives port_ext; bus and port levels are resolved here
`timescale 1ns/10ps
interface gpio_pins_if;
	logic [7:0]      data_h;
	logic            data_h_oe;
	logic [7:0]      data_d;
	logic            data_d_oe;
	logic [7:0]      data_lvl;
	logic [2:0]      addr;
	logic            chip_select_low;
	logic            write_strobe_low;
	logic            read_strobe_low;
	logic            standalone_mode_select;
	logic            output_hold_low;
	logic            output_enable_low;
	logic [3:0][7:0] port_out;
	logic [3:0][7:0] port_oe;
	logic [3:0][7:0] port_ext;
	logic [3:0][7:0] port_lvl;

	// undriven bus reads high through the board pull-ups
	assign data_lvl = data_d_oe ? data_d : (data_h_oe ? data_h : gpio_pkg::BUS_PULLUP);
	assign port_lvl = (port_out & port_oe) | (port_ext & ~port_oe);

	modport dev (
		input  data_lvl, addr, chip_select_low, write_strobe_low, read_strobe_low,
		input  standalone_mode_select, output_hold_low, output_enable_low, port_lvl,
		output data_d, data_d_oe, port_out, port_oe
	);
	modport host (
		input  data_lvl,
		output data_h, data_h_oe, addr, chip_select_low, write_strobe_low, read_strobe_low,
		output standalone_mode_select, output_hold_low, output_enable_low
	);
endinterface

// File: verilog/gpio_pkg.sv
// shared constants for the gpio pin-level ends: timing, field layout, reset values
// assumes a 100 MHz core clock on both ends
package gpio_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int NOMINAL_CLK_MHZ = 16;
	localparam int FILT_BASE_NS = 1000;
	localparam int FILT_BASE_CYC = (FILT_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILT_CNT_W = 24;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 3;
	localparam int PORT_W = 8;
	localparam int NUM_PORTS = 4;
	localparam int PORT_A = 0;
	localparam int PORT_B = 1;
	localparam int PORT_C = 2;
	localparam int PORT_D = 3;
	// device map: address bit 2 picks direction bank, bits 1:0 pick the port
	localparam int DEV_DIR_BIT = 2;
	localparam logic [7:0] DEV_OUT_RST = 8'h00;
	localparam logic [7:0] DEV_DIR_RST = 8'h00;
	// host command port map
	localparam logic [2:0] HOST_CMD = 3'h0;
	localparam logic [2:0] HOST_WDATA = 3'h1;
	localparam logic [2:0] HOST_STATUS = 3'h2;
	localparam logic [2:0] HOST_RDATA = 3'h3;
	localparam logic [2:0] HOST_CFG0 = 3'h4;
	localparam logic [2:0] HOST_CFG1 = 3'h5;
	localparam logic [2:0] HOST_MODE = 3'h6;
	localparam int CMD_READ_BIT = 3;
	localparam int CFG1_CSN_BIT = 3;
	localparam int CFG1_PORT_A_FILTER_ENABLE_PIN_BIT = 4;
	localparam int CFG1_PORT_B_FILTER_ENABLE_PIN_BIT = 5;
	localparam int CFG1_HOLDN_BIT = 6;
	localparam int CFG1_OEN_BIT = 7;
	localparam logic [7:0] CFG0_RST = 8'h00;
	localparam logic [7:0] CFG1_RST = 8'hC0;
	localparam logic [7:0] MODE_RST = 8'h01;
	// host bus timing
	localparam int SETUP_NS = 20;
	localparam int STROBE_NS = 80;
	localparam int HOLD_NS = 30;
	localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] BUS_PULLUP = 8'hFF;
	typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD} host_state_e;
endpackage

// File: verilog/integ_filter.sv
// one-bit integral filter: up/down counter with hysteresis at 0 and limit
// assumes its input is already synchronous to clk_i
`timescale 1ns/10ps
module integ_filter #(
	parameter int CNT_W = 24
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             in_i,
	input  wire logic             en_i,
	input  wire logic [CNT_W-1:0] limit_i,
	output logic                  out_o
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             out;
	} filt_s;

	filt_s r;
	filt_s n;

	always_comb begin
		n = r;
		if (!en_i) begin
			// bypass: pass the level straight through
			n.cnt = '0;
			n.out = in_i;
		end else begin
			if (in_i && r.cnt < limit_i)
				n.cnt = r.cnt + 1'b1;
			else if (!in_i && r.cnt != '0)
				n.cnt = r.cnt - 1'b1;
			// hysteresis: a noisy input only moves the count, not the output
			if (n.cnt >= limit_i)
				n.out = 1'b1;
			else if (n.cnt == '0)
				n.out = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			r <= '0;
		else
			r <= n;
	end

	assign out_o = r.out;
endmodule
